// ===== verilog/acq_cfg_pkg.sv
// constants for the acquisition configuration block: register map, fields, resets, timing
// assumes a 200 MHz core clock and an Avalon-MM register bus with byte addresses
// Overview of operation
// - Stored calibration is applied to scan results only while the calibration apply bit (14) is one.
// - The calibration apply bit never alters comparator results or the comparator self-test.
// - With the accuracy check bit (13) set, the comparator is self-tested after each sequence with scan setting 001 or 010 that ends while no self-test runs.
// - The self-test brackets the comparator between upper and lower thresholds and raises a high or low alert on a bad result.
// - The frequency field (12:11) picks the rate: 00 by enabled features, 01 gives 1.60 kHz, 1x gives 1.92 kHz.
// - The chosen fixed rate governs converter and comparator scans only while the oversample count is above 000.
// - With field 00 sampling runs as fast as channels, diagnostics and overhead allow, about 2.2 kHz at worst.
// - The bias mode field (10:9) closes the switch during acquisition for 0x, keeps it open for 10, closed for 11.
// - A closed bias switch connects the analog supply to the thermistor bias pin.
// - The delay register holds the cell-path delay in 15:8 and switch-path delay in 7:0, read-write, reset 0x00.
// - Each delay lasts its field value times 96 us, from zero up to 24.480 ms, before measuring starts.
package acq_cfg_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] ACQ_CFG_IDX  = 8'h62;
  localparam logic [7:0] BAL_DLY_IDX  = 8'h63;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h70;
  localparam logic [7:0] IRQ_CLR_IDX  = 8'h71;
  localparam logic [7:0] IRQ_EN_IDX   = 8'h72;
  localparam int ADDR_W = 10;

  // acquisition configuration fields
  localparam int CAL_EN_BIT    = 14;
  localparam int ACC_EN_BIT    = 13;
  localparam int RATE_LSB      = 11;
  localparam int BIAS_LSB      = 9;
  localparam logic [15:0] ACQ_CFG_MASK  = 16'h7E00;
  localparam logic [15:0] ACQ_CFG_RESET = 16'h0000;
  localparam logic [15:0] BAL_DLY_RESET = 16'h0000;
  localparam int CELL_DLY_LSB = 8;
  localparam int SW_DLY_LSB   = 0;

  // scan settings that use the comparator, and the no-oversampling count code
  localparam logic [2:0] SCAN_COMP_A = 3'h1;
  localparam logic [2:0] SCAN_COMP_B = 3'h2;
  localparam logic [2:0] OVS_NONE    = 3'h0;

  // frequency and bias mode codes
  localparam logic [1:0] RATE_AUTO   = 2'h0;
  localparam logic [1:0] RATE_1600   = 2'h1;
  localparam logic [1:0] BIAS_OFF    = 2'h2;
  localparam logic [1:0] BIAS_ON     = 2'h3;

  // interrupt status bits
  localparam int IRQ_W        = 3;
  localparam int IRQ_HIGH_BIT = 0;
  localparam int IRQ_LOW_BIT  = 1;
  localparam int IRQ_DLY_BIT  = 2;

  // timing
  localparam int CLK_HZ        = 200000000;
  localparam int CLK_MHZ       = 200;
  localparam int DLY_STEP_US   = 96;
  localparam int DLY_STEP_CYC  = DLY_STEP_US * CLK_MHZ;
  localparam int RATE_A_HZ     = 1600;
  localparam int RATE_B_HZ     = 1920;
  localparam int RATE_A_CYC    = (CLK_HZ + RATE_A_HZ - 1) / RATE_A_HZ;
  localparam int RATE_B_CYC    = (CLK_HZ + RATE_B_HZ - 1) / RATE_B_HZ;
  localparam int AUTO_WORST_HZ = 2200;

  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN  = 2'b01
  } chk_state_type;
endpackage

// ===== verilog/step_delay_timer.sv
// step-scaled delay timer: waits steps_i times STEP_CYC cycles, then pulses done_o
// assumes start_i is a single-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module step_delay_timer #(
  parameter int STEP_CYC = 19200,
  parameter int STEP_W   = 8
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // request
  input  wire logic              start_i,
  input  wire logic [STEP_W-1:0] steps_i,
  // status
  output logic                   busy_o,
  output logic                   done_o
);
  localparam int PRE_W = $clog2(STEP_CYC);

  logic [PRE_W-1:0]  pre_r;
  logic [STEP_W-1:0] left_r;
  logic              last_pre;

  assign last_pre = (pre_r == PRE_W'(STEP_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r  <= '0;
      left_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        pre_r  <= '0;
        left_r <= steps_i;
        busy_o <= (steps_i != '0);
        // zero steps: no wait at all
        done_o <= (steps_i == '0);
      end
      else if (busy_o)
      begin
        pre_r <= last_pre ? '0 : pre_r + 1'b1;
        if (last_pre)
        begin
          left_r <= left_r - 1'b1;
          if (left_r == STEP_W'(1))
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule // step_delay_timer

// ===== verilog/acq_cfg_ctrl.sv
// acquisition configuration control: config registers, calibration select, comparator
// self-test sequencing, sampling-rate ticks, thermistor bias switch, balancing delays
// assumes sequencer, comparator and converter signals come from logic on CLOCK_I
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module acq_cfg_ctrl #(
  parameter int RES_W        = 16,
  parameter int DLY_STEP_CYC = acq_cfg_pkg::DLY_STEP_CYC,
  parameter int RATE_A_CYC   = acq_cfg_pkg::RATE_A_CYC,
  parameter int RATE_B_CYC   = acq_cfg_pkg::RATE_B_CYC
) (
  // clock, reset, enable
  input  wire logic                            CLOCK_I,
  input  wire logic                            RESET_I,
  input  wire logic                            CE_I,
  // avalon-mm slave
  input  wire logic [acq_cfg_pkg::ADDR_W-1:0]  ADDRESS_I,
  input  wire logic                            READ_I,
  input  wire logic                            WRITE_I,
  input  wire logic [3:0]                      BYTEENABLE_I,
  input  wire logic [31:0]                     WRITEDATA_I,
  output logic [31:0]                          READDATA_O,
  output logic                                 WAITREQUEST_O,
  output logic                                 IRQ_O,
  // scan results
  input  wire logic                            RESULT_VALID_I,
  input  wire logic [RES_W-1:0]                RESULT_RAW_I,
  input  wire logic [RES_W-1:0]                RESULT_CAL_I,
  output logic                                 RESULT_VALID_O,
  output logic [RES_W-1:0]                     RESULT_O,
  input  wire logic                            COMP_VALID_I,
  input  wire logic                            COMP_RESULT_I,
  output logic                                 COMP_VALID_O,
  output logic                                 COMP_RESULT_O,
  // sequencer
  input  wire logic                            SEQ_DONE_I,
  input  wire logic [2:0]                      SCAN_CONFIGURATION_I,
  input  wire logic [2:0]                      OVERSAMPLE_COUNT_SELECT_I,
  input  wire logic                            FEATURE_READY_I,
  input  wire logic                            ACQ_ACTIVE_I,
  output logic                                 SAMPLE_TICK_O,
  // comparator self-test
  output logic                                 CHK_REQ_O,
  output logic                                 QUARTER_GAIN_PATH_O,
  input  wire logic                            CHK_DONE_I,
  input  wire logic                            CHK_ABOVE_UPPER_I,
  input  wire logic                            CHK_BELOW_LOWER_I,
  // thermistor bias
  output logic                                 THERMISTOR_BIAS_SWITCH_O,
  // balancing delay
  input  wire logic                            BAL_DLY_START_I,
  input  wire logic                            BAL_DLY_SWITCH_PATH_I,
  output logic                                 BAL_DLY_BUSY_O,
  output logic                                 BAL_DLY_DONE_O
);
  logic [15:0]                  acq_cfg_r;
  logic [15:0]                  bal_dly_r;
  logic [acq_cfg_pkg::IRQ_W-1:0] stat_r;
  logic [acq_cfg_pkg::IRQ_W-1:0] irq_en_r;
  logic [acq_cfg_pkg::IRQ_W-1:0] stat_set;
  logic [acq_cfg_pkg::IRQ_W-1:0] stat_clr;
  logic                         ack_r;
  logic                         wr_go;
  logic [7:0]                   idx;
  logic [15:0]                  wdat16;
  logic [15:0]                  bmask;
  acq_cfg_pkg::chk_state_type   chk_state_r;
  logic [16:0]                  rate_cnt_r;
  logic [16:0]                  rate_top;
  logic                         fixed_rate;
  logic [7:0]                   dly_steps;

  // field views
  logic       cal_en;
  logic       acc_en;
  logic [1:0] rate_sel;
  logic [1:0] bias_mode;
  assign cal_en    = acq_cfg_r[acq_cfg_pkg::CAL_EN_BIT];
  assign acc_en    = acq_cfg_r[acq_cfg_pkg::ACC_EN_BIT];
  assign rate_sel  = acq_cfg_r[acq_cfg_pkg::RATE_LSB +: 2];
  assign bias_mode = acq_cfg_r[acq_cfg_pkg::BIAS_LSB +: 2];

  function automatic logic uses_comparator(input logic [2:0] scan);
    uses_comparator = (scan == acq_cfg_pkg::SCAN_COMP_A) || (scan == acq_cfg_pkg::SCAN_COMP_B);
  endfunction

  // bus: one wait state, so read data can come from a flop
  assign idx           = ADDRESS_I[acq_cfg_pkg::ADDR_W-1:2];
  assign WAITREQUEST_O = (READ_I | WRITE_I) & ~ack_r;
  assign wr_go         = WRITE_I & ack_r;
  assign wdat16        = WRITEDATA_I[15:0];
  assign bmask         = {{8{BYTEENABLE_I[1]}}, {8{BYTEENABLE_I[0]}}};

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      ack_r <= 1'b0;
    else if (CE_I)
      ack_r <= (READ_I | WRITE_I) & ~ack_r;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      READDATA_O <= 32'h0000_0000;
    else if (CE_I && READ_I && !ack_r)
    begin
      if (idx == acq_cfg_pkg::ACQ_CFG_IDX)
        READDATA_O <= {16'h0000, acq_cfg_r};
      else if (idx == acq_cfg_pkg::BAL_DLY_IDX)
        READDATA_O <= {16'h0000, bal_dly_r};
      else if (idx == acq_cfg_pkg::IRQ_STAT_IDX)
        READDATA_O <= {29'h0000_0000, stat_r};
      else if (idx == acq_cfg_pkg::IRQ_EN_IDX)
        READDATA_O <= {29'h0000_0000, irq_en_r};
      else
        READDATA_O <= 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      acq_cfg_r <= acq_cfg_pkg::ACQ_CFG_RESET;
    else if (CE_I && wr_go && idx == acq_cfg_pkg::ACQ_CFG_IDX)
      acq_cfg_r <= ((acq_cfg_r & ~bmask) | (wdat16 & bmask)) & acq_cfg_pkg::ACQ_CFG_MASK;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      bal_dly_r <= acq_cfg_pkg::BAL_DLY_RESET;
    else if (CE_I && wr_go && idx == acq_cfg_pkg::BAL_DLY_IDX)
      bal_dly_r <= (bal_dly_r & ~bmask) | (wdat16 & bmask);
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      irq_en_r <= '0;
    else if (CE_I && wr_go && idx == acq_cfg_pkg::IRQ_EN_IDX && BYTEENABLE_I[0])
      irq_en_r <= WRITEDATA_I[acq_cfg_pkg::IRQ_W-1:0];
  end

  // interrupts: a set in the same cycle as its clear wins
  assign stat_clr = (wr_go && idx == acq_cfg_pkg::IRQ_CLR_IDX && BYTEENABLE_I[0])
                    ? WRITEDATA_I[acq_cfg_pkg::IRQ_W-1:0] : '0;
  always_comb
  begin
    stat_set = '0;
    if (chk_state_r == acq_cfg_pkg::CHK_RUN && CHK_DONE_I)
    begin
      stat_set[acq_cfg_pkg::IRQ_HIGH_BIT] = CHK_ABOVE_UPPER_I;
      stat_set[acq_cfg_pkg::IRQ_LOW_BIT]  = CHK_BELOW_LOWER_I;
    end
    stat_set[acq_cfg_pkg::IRQ_DLY_BIT] = BAL_DLY_DONE_O;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      stat_r <= '0;
    else if (CE_I)
      stat_r <= (stat_r & ~stat_clr) | stat_set;
  end

  assign IRQ_O = |(stat_r & irq_en_r);

  // result path; the comparator path never looks at the calibration bit
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      RESULT_VALID_O <= 1'b0;
      RESULT_O       <= '0;
    end
    else if (CE_I)
    begin
      RESULT_VALID_O <= RESULT_VALID_I;
      if (RESULT_VALID_I)
        RESULT_O <= cal_en ? RESULT_CAL_I : RESULT_RAW_I;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      COMP_VALID_O  <= 1'b0;
      COMP_RESULT_O <= 1'b0;
    end
    else if (CE_I)
    begin
      COMP_VALID_O <= COMP_VALID_I;
      if (COMP_VALID_I)
        COMP_RESULT_O <= COMP_RESULT_I;
    end
  end

  // comparator self-test after a comparator sequence
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      chk_state_r <= acq_cfg_pkg::CHK_IDLE;
    else if (CE_I)
    begin
      case (chk_state_r)
        acq_cfg_pkg::CHK_IDLE:
          if (SEQ_DONE_I && acc_en && uses_comparator(SCAN_CONFIGURATION_I))
            chk_state_r <= acq_cfg_pkg::CHK_RUN;
        acq_cfg_pkg::CHK_RUN:
          if (CHK_DONE_I)
            chk_state_r <= acq_cfg_pkg::CHK_IDLE;
        default:
          chk_state_r <= acq_cfg_pkg::CHK_IDLE;
      endcase
    end
  end

  // reference routed through the quarter-gain path for the whole test
  assign CHK_REQ_O           = (chk_state_r == acq_cfg_pkg::CHK_RUN);
  assign QUARTER_GAIN_PATH_O = (chk_state_r == acq_cfg_pkg::CHK_RUN);

  // sample rate: fixed only with oversampling and a non-auto frequency
  assign fixed_rate = (OVERSAMPLE_COUNT_SELECT_I != acq_cfg_pkg::OVS_NONE)
                      && (rate_sel != acq_cfg_pkg::RATE_AUTO);
  assign rate_top   = (rate_sel == acq_cfg_pkg::RATE_1600) ? 17'(RATE_A_CYC - 1) : 17'(RATE_B_CYC - 1);

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      rate_cnt_r    <= '0;
      SAMPLE_TICK_O <= 1'b0;
    end
    else if (CE_I)
    begin
      if (fixed_rate)
      begin
        rate_cnt_r    <= (rate_cnt_r >= rate_top) ? '0 : rate_cnt_r + 1'b1;
        SAMPLE_TICK_O <= (rate_cnt_r >= rate_top);
      end
      else
      begin
        // as fast as the enabled features let the front end go
        rate_cnt_r    <= '0;
        SAMPLE_TICK_O <= FEATURE_READY_I;
      end
    end
  end

  // bias switch: closing it puts the analog supply on the bias pin
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      THERMISTOR_BIAS_SWITCH_O <= 1'b0;
    else if (CE_I)
    begin
      case (bias_mode)
        acq_cfg_pkg::BIAS_OFF: THERMISTOR_BIAS_SWITCH_O <= 1'b0;
        acq_cfg_pkg::BIAS_ON:  THERMISTOR_BIAS_SWITCH_O <= 1'b1;
        default:               THERMISTOR_BIAS_SWITCH_O <= ACQ_ACTIVE_I;
      endcase
    end
  end

  // balancing recovery delay
  assign dly_steps = BAL_DLY_SWITCH_PATH_I ? bal_dly_r[acq_cfg_pkg::SW_DLY_LSB +: 8]
                                           : bal_dly_r[acq_cfg_pkg::CELL_DLY_LSB +: 8];

  step_delay_timer #(
    .STEP_CYC (DLY_STEP_CYC),
    .STEP_W   (8)
  ) u_dly (
    .clk_i   (CLOCK_I),
    .rst_i   (RESET_I),
    .ce_i    (CE_I),
    .start_i (BAL_DLY_START_I),
    .steps_i (dly_steps),
    .busy_o  (BAL_DLY_BUSY_O),
    .done_o  (BAL_DLY_DONE_O)
  );

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  property p_cal_select;
    CE_I && RESULT_VALID_I |=> RESULT_O == ($past(cal_en) ? $past(RESULT_CAL_I) : $past(RESULT_RAW_I));
  endproperty
  a_cal_select: assert property (p_cal_select) else $error("result source wrong");

  property p_comp_pass;
    CE_I && COMP_VALID_I |=> COMP_RESULT_O == $past(COMP_RESULT_I);
  endproperty
  a_comp_pass: assert property (p_comp_pass) else $error("comparator result altered");

  sequence s_comp_seq_end;
    CE_I && SEQ_DONE_I && acc_en && uses_comparator(SCAN_CONFIGURATION_I) && !CHK_REQ_O;
  endsequence
  property p_chk_start;
    s_comp_seq_end |=> CHK_REQ_O && QUARTER_GAIN_PATH_O;
  endproperty
  a_chk_start: assert property (p_chk_start) else $error("self-test not started");

  property p_chk_off;
    !acc_en && !CHK_REQ_O |=> !CHK_REQ_O;
  endproperty
  a_chk_off: assert property (p_chk_off) else $error("self-test while disabled");

  property p_high_alert;
    CE_I && CHK_REQ_O && CHK_DONE_I && CHK_ABOVE_UPPER_I |=> stat_r[acq_cfg_pkg::IRQ_HIGH_BIT];
  endproperty
  a_high_alert: assert property (p_high_alert) else $error("high alert missing");

  property p_low_alert;
    CE_I && CHK_REQ_O && CHK_DONE_I && CHK_BELOW_LOWER_I |=> stat_r[acq_cfg_pkg::IRQ_LOW_BIT];
  endproperty
  a_low_alert: assert property (p_low_alert) else $error("low alert missing");

  property p_auto_rate;
    CE_I && !fixed_rate |=> SAMPLE_TICK_O == $past(FEATURE_READY_I);
  endproperty
  a_auto_rate: assert property (p_auto_rate) else $error("feature-rate tick wrong");

  property p_fixed_rate;
    CE_I && fixed_rate && rate_cnt_r < rate_top |=> !SAMPLE_TICK_O;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("early fixed-rate tick");

  property p_bias;
    CE_I |=> THERMISTOR_BIAS_SWITCH_O == ($past(bias_mode) == acq_cfg_pkg::BIAS_ON
             || ($past(bias_mode) != acq_cfg_pkg::BIAS_OFF && $past(bias_mode) != acq_cfg_pkg::BIAS_ON
                 && $past(ACQ_ACTIVE_I)));
  endproperty
  a_bias: assert property (p_bias) else $error("bias switch wrong");

  property p_unused_zero;
    (acq_cfg_r & ~acq_cfg_pkg::ACQ_CFG_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_zero_delay;
    CE_I && BAL_DLY_START_I && dly_steps == 8'h00 |=> BAL_DLY_DONE_O && !BAL_DLY_BUSY_O;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");
endmodule // acq_cfg_ctrl

// ===== bench/acquisition_config_control_bench.sv
// self-checking bench for acq_cfg_ctrl: registers, result select, self-test, alerts, rate, bias, delays
// assumes the package and design files under verilog/ are compiled first; timer parameters are shortened
`timescale 1ns/1ps
module acquisition_config_control_bench;
  localparam int STEP  = 4;
  localparam int PER_A = 10;
  localparam int PER_B = 8;
  localparam logic [9:0] A_CFG  = {acq_cfg_pkg::ACQ_CFG_IDX, 2'b00};
  localparam logic [9:0] A_DLY  = {acq_cfg_pkg::BAL_DLY_IDX, 2'b00};
  localparam logic [9:0] A_STAT = {acq_cfg_pkg::IRQ_STAT_IDX, 2'b00};
  localparam logic [9:0] A_CLR  = {acq_cfg_pkg::IRQ_CLR_IDX, 2'b00};
  localparam logic [9:0] A_EN   = {acq_cfg_pkg::IRQ_EN_IDX, 2'b00};
  localparam logic [9:0] A_BAD  = 10'h3FC;

  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        read = 1'b0, write = 1'b0, rv = 1'b0, cv = 1'b0, cr = 1'b0, seq_done = 1'b0, feat = 1'b0;
  logic        acq = 1'b0, chk_done = 1'b0, above = 1'b0, below = 1'b0, dstart = 1'b0, dsw = 1'b0;
  logic [9:0]  address = 10'h000;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] rraw = 16'h0000, rcal = 16'h0000;
  logic [2:0]  scan = 3'h0, ovs = 3'h0;
  logic [31:0] rdata;
  logic [15:0] res_o;
  logic        waitreq, irq, rv_o, cv_o, cr_o, tick, chk_req, qgp, bias_sw, dbusy, ddone;
  int          errors = 0;
  int          tests_run = 0;

  always #2.5 clock = ~clock;

  acq_cfg_ctrl #(.RES_W(16), .DLY_STEP_CYC(STEP), .RATE_A_CYC(PER_A), .RATE_B_CYC(PER_B)) i_dut (
    .CLOCK_I(clock), .RESET_I(reset), .CE_I(ce),
    .ADDRESS_I(address), .READ_I(read), .WRITE_I(write), .BYTEENABLE_I(be), .WRITEDATA_I(wdata),
    .READDATA_O(rdata), .WAITREQUEST_O(waitreq), .IRQ_O(irq),
    .RESULT_VALID_I(rv), .RESULT_RAW_I(rraw), .RESULT_CAL_I(rcal), .RESULT_VALID_O(rv_o), .RESULT_O(res_o),
    .COMP_VALID_I(cv), .COMP_RESULT_I(cr), .COMP_VALID_O(cv_o), .COMP_RESULT_O(cr_o),
    .SEQ_DONE_I(seq_done), .SCAN_CONFIGURATION_I(scan), .OVERSAMPLE_COUNT_SELECT_I(ovs),
    .FEATURE_READY_I(feat), .ACQ_ACTIVE_I(acq), .SAMPLE_TICK_O(tick),
    .CHK_REQ_O(chk_req), .QUARTER_GAIN_PATH_O(qgp), .CHK_DONE_I(chk_done),
    .CHK_ABOVE_UPPER_I(above), .CHK_BELOW_LOWER_I(below), .THERMISTOR_BIAS_SWITCH_O(bias_sw),
    .BAL_DLY_START_I(dstart), .BAL_DLY_SWITCH_PATH_I(dsw), .BAL_DLY_BUSY_O(dbusy), .BAL_DLY_DONE_O(ddone)
  );

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge, released only after it
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] lanes,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    read <= ~wr; write <= wr; address <= a; wdata <= d; be <= lanes;
    do
    begin
      @(posedge clock);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (n >= 100) chk(32'h0, 32'h1, "bus answer timeout");
    q = rdata;
    read <= 1'b0; write <= 1'b0;
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task rd(input logic [9:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, exp, what);
  endtask

  task irq_is(input logic exp);
    @(negedge clock);
    chk(irq, exp, "interrupt level");
  endtask

  task t_regs;
    logic [31:0] q;
    rd(A_CFG, 32'h0000_0000, "config reset");
    rd(A_DLY, 32'h0000_0000, "delay reset");
    wr(A_CFG, 32'hFFFF_FFFF);
    rd(A_CFG, 32'h0000_7E00, "config used bits only");
    wr(A_DLY, 32'h0000_A55A);
    rd(A_DLY, 32'h0000_A55A, "delay fields");
    bus(1'b1, A_DLY, 32'h0000_FFFF, 4'h1, q);
    rd(A_DLY, 32'h0000_A5FF, "switch-path byte alone");
    rd(A_EN, 32'h0000_0000, "enable reset");
    rd(A_BAD, 32'h0000_0000, "unmapped reads zero");
    wr(A_CFG, 32'h0000_0000);
  endtask

  task t_result(input logic calen);
    wr(A_CFG, {17'h0, calen, 14'h0});
    @(posedge clock);
    rv <= 1'b1; rraw <= 16'h1234; rcal <= 16'hABCD; cv <= 1'b1; cr <= ~calen;
    @(posedge clock);
    rv <= 1'b0; cv <= 1'b0;
    @(negedge clock);
    chk(rv_o, 1'b1, "result strobe");
    chk(res_o, calen ? 16'hABCD : 16'h1234, "result word");
    chk({cv_o, cr_o}, {1'b1, ~calen}, "comparator copy");
  endtask

  // one end of sequence; when a test is expected it is finished with the given outcome flags
  task st(input logic [2:0] s, input logic up, input logic lo, input logic exp);
    @(posedge clock);
    seq_done <= 1'b1; scan <= s;
    @(posedge clock);
    seq_done <= 1'b0;
    @(negedge clock);
    chk({chk_req, qgp}, {exp, exp}, "self-test request");
    if (exp)
    begin
      repeat (3) @(negedge clock);
      chk(chk_req, 1'b1, "request held");
      @(posedge clock);
      chk_done <= 1'b1; above <= up; below <= lo;
      @(posedge clock);
      chk_done <= 1'b0; above <= 1'b0; below <= 1'b0;
      @(negedge clock);
      chk(chk_req, 1'b0, "request ends");
    end
  endtask

  task t_selftest;
    wr(A_CFG, 32'h0000_0000);
    st(3'h1, 1'b0, 1'b0, 1'b0);
    wr(A_CFG, 32'h0000_6000);
    for (int s = 0; s < 8; s++) st(s[2:0], 1'b0, 1'b0, s == 1 || s == 2);
    rd(A_STAT, 32'h0000_0000, "no alert on good result");
    st(3'h2, 1'b1, 1'b0, 1'b1);
    rd(A_STAT, 32'h0000_0001, "high alert");
    irq_is(1'b0);
    wr(A_EN, 32'h0000_0007);
    irq_is(1'b1);
    wr(A_CLR, 32'h0000_0001);
    rd(A_STAT, 32'h0000_0000, "high alert cleared");
    irq_is(1'b0);
    st(3'h1, 1'b0, 1'b1, 1'b1);
    rd(A_STAT, 32'h0000_0002, "low alert");
    wr(A_CLR, 32'h0000_0002);
  endtask

  task dly(input logic sw, input int n);
    int c;
    @(posedge clock);
    dstart <= 1'b1; dsw <= sw;
    @(posedge clock);
    dstart <= 1'b0;
    c = 0;
    do
    begin
      @(negedge clock);
      c++;
      if (c == 1 && n > 0) chk(dbusy, 1'b1, "delay busy");
    end while (ddone !== 1'b1 && c < 2000);
    chk(c, n * STEP + 1, "delay length");
  endtask

  task t_delay;
    wr(A_DLY, 32'h0000_0300);
    dly(1'b0, 3);
    dly(1'b1, 0);
    wr(A_DLY, 32'h0000_FF02);
    dly(1'b0, 255);
    dly(1'b1, 2);
    rd(A_STAT, 32'h0000_0004, "delay done flag");
    wr(A_CLR, 32'h0000_0004);
    irq_is(1'b0);
  endtask

  // per zero means ticks must come only from the front-end ready strobe
  task rate(input logic [1:0] f, input logic [2:0] o, input int per);
    int n;
    n = 0;
    wr(A_CFG, {19'h0, f, 11'h0});
    @(posedge clock);
    ovs <= o;
    if (per == 0)
    begin
      repeat (24)
      begin
        @(negedge clock);
        if (tick === 1'b1) n++;
      end
      chk(n, 0, "no free-running tick");
      @(posedge clock);
      feat <= 1'b1;
      @(posedge clock);
      feat <= 1'b0;
      @(negedge clock);
      chk(tick, 1'b1, "tick follows ready");
    end
    else
    begin
      do
      begin
        @(negedge clock);
        n++;
      end while (tick !== 1'b1 && n < 50);
      n = 0;
      do
      begin
        @(negedge clock);
        n++;
      end while (tick !== 1'b1 && n < 50);
      chk(n, per, "tick period");
    end
  endtask

  task t_rate;
    rate(2'h0, 3'h3, 0);
    rate(2'h1, 3'h0, 0);
    rate(2'h1, 3'h3, PER_A);
    rate(2'h2, 3'h1, PER_B);
    rate(2'h3, 3'h7, PER_B);
  endtask

  task bias(input logic [1:0] m);
    wr(A_CFG, {21'h0, m, 9'h0});
    for (int a = 0; a < 2; a++)
    begin
      @(posedge clock);
      acq <= a[0];
      repeat (2) @(negedge clock);
      chk(bias_sw, m == 2'h3 ? 1'b1 : (m == 2'h2 ? 1'b0 : a[0]), "bias switch");
    end
  endtask

  task t_bias;
    for (int m = 0; m < 4; m++) bias(m[1:0]);
    // enable low must hold the switch although its input moves
    wr(A_CFG, 32'h0000_0000);
    @(posedge clock);
    ce <= 1'b0;
    acq <= 1'b0;
    repeat (4) @(negedge clock);
    chk(bias_sw, 1'b1, "switch frozen by enable");
    @(posedge clock);
    ce <= 1'b1;
    repeat (2) @(negedge clock);
    chk(bias_sw, 1'b0, "switch follows after enable");
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_result(1'b0);
    t_result(1'b1);
    t_selftest();
    t_delay();
    t_rate();
    t_bias();
    results();
  end

  // whole run is under two thousand cycles; this leaves a wide margin
  initial
  begin
    #100000;
    errors++;
    results();
  end
endmodule // acquisition_config_control_bench
